//--- otp_mem_seq.v
// memory and status command sequencer of the otp eprom
`timescale 1ns/100ps
`include "otp_seq_regs.vh"
`default_nettype none

module otp_mem_seq
#(
  parameter PROG_CYC = `PROG_US * `CLK_MHZ
)
(
  input  wire clk_sys,
  input  wire rst_b,
  input  wire rst_pulse,
  input  wire wr_bit_valid,
  input  wire wr_bit,
  input  wire rd_slot,
  input  wire prog_pin,
  output reg  rd_bit_ff,
  output reg  rd_bit_vld_ff,
  output reg  presence_ff,
  output reg  prog_done_ff
);

  // ==========================================================
  // states
  localparam [12:0] S_IDLE  = 13'h0001;
  localparam [12:0] S_FUNC  = 13'h0002;
  localparam [12:0] S_ADRL  = 13'h0004;
  localparam [12:0] S_ADRH  = 13'h0008;
  localparam [12:0] S_CACRC = 13'h0010;
  localparam [12:0] S_RDATA = 13'h0020;
  localparam [12:0] S_RCRC  = 13'h0040;
  localparam [12:0] S_ONES  = 13'h0080;
  localparam [12:0] S_WDATA = 13'h0100;
  localparam [12:0] S_WCRC  = 13'h0200;
  localparam [12:0] S_WPROG = 13'h0400;
  localparam [12:0] S_WPULS = 13'h0800;
  localparam [12:0] S_WVER  = 13'h1000;

  // ==========================================================
  // crc and status contents
  function [7:0] crc_byte;
    input [7:0] crc;
    input [7:0] data;
    integer     k;
    reg   [7:0] c;
    begin
      c = crc;
      for (k = 0; k < 8; k = k + 1)
      begin
        if (c[0] ^ data[k])
          c = (c >> 1) ^ `CRC_POLY_REFL;
        else
          c = c >> 1;
      end
      crc_byte = c;
    end
  endfunction

  // only the last status byte is factory set
  function [7:0] stat_byte;
    input [2:0] idx;
    begin
      if (idx == `STAT_LAST)
        stat_byte = `STAT_FACTORY;
      else
        stat_byte = `STAT_ERASED;
    end
  endfunction

  // ==========================================================
  // declarations
  reg  [12:0] state_ff;
  reg  [12:0] nxt_state;
  reg  [7:0]  cmd_ff;
  reg  [15:0] addr_ff;
  reg  [7:0]  crc_ff;
  reg  [7:0]  rx_sh_ff;
  reg  [2:0]  rx_cnt_ff;
  reg  [2:0]  idx_ff;
  reg  [7:0]  mem_ff [0:`MEM_BYTES-1];
  reg  [7:0]  buf_ff [0:7];
  reg         prog_s1_ff;
  reg         prog_s2_ff;
  reg         prog_s3_ff;
  reg  [15:0] prog_cnt_ff;
  reg  [7:0]  tx_sh_ff;
  reg  [2:0]  tx_left_ff;
  reg         push_vld;
  reg  [7:0]  push_data;
  wire        push_rdy;
  wire        pop_vld;
  wire [7:0]  pop_data;
  wire        pop_rdy;
  wire        rx_done;
  wire [7:0]  rx_byte;
  wire        accepted;
  wire        is_stat;
  wire        is_page;
  wire        is_write;
  wire        at_end;
  wire        rst_ok;
  wire        commit;
  wire        buf_we;
  integer     i;

  assign rx_done  = wr_bit_valid && (rx_cnt_ff == 3'h7);
  assign rx_byte  = {wr_bit, rx_sh_ff[7:1]};
  assign accepted = push_vld && push_rdy;
  assign is_stat  = (cmd_ff == `CMD_RD_STAT);
  assign is_page  = (cmd_ff == `CMD_RD_PAGE);
  assign is_write = (cmd_ff == `CMD_WR_MEM);
  assign at_end   = is_stat ? (addr_ff[15:3] != 13'h0000) : (addr_ff[15:7] != 9'h000);
  // line sits at programming voltage, a low reset cannot be real there
  assign rst_ok   = rst_pulse && !((state_ff == S_WPULS) && prog_s2_ff);
  assign commit   = (state_ff == S_WPULS) && prog_s3_ff && !prog_s2_ff;
  assign buf_we   = (state_ff == S_WDATA) && rx_done;

  // ==========================================================
  // programming pin synchroniser and pulse length
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prog_s1_ff  <= 1'b0;
      prog_s2_ff  <= 1'b0;
      prog_s3_ff  <= 1'b0;
      prog_cnt_ff <= 16'h0000;
    end
    else
    begin
      prog_s1_ff <= prog_pin;
      prog_s2_ff <= prog_s1_ff;
      prog_s3_ff <= prog_s2_ff;
      if (!prog_s2_ff || (state_ff != S_WPULS))
        prog_cnt_ff <= 16'h0000;
      else if (prog_cnt_ff != 16'hffff)
        prog_cnt_ff <= prog_cnt_ff + 1'b1;
    end
  end

  // ==========================================================
  // eprom array and ram buffer
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (i = 0; i < `MEM_BYTES; i = i + 1)
        mem_ff[i] <= `DATA_ERASED;
      for (i = 0; i < 8; i = i + 1)
        buf_ff[i] <= `DATA_ERASED;
    end
    else
    begin
      if (rst_ok)
      begin
        for (i = 0; i < 8; i = i + 1)
          buf_ff[i] <= `DATA_ERASED;
      end
      else if (buf_we)
        buf_ff[idx_ff] <= rx_byte;
      // a pulse shorter than the minimum leaves the cells untouched
      if (commit && (prog_cnt_ff >= PROG_CYC[15:0]))
      begin
        for (i = 0; i < 8; i = i + 1)
          mem_ff[{addr_ff[6:3], i[2:0]}] <= mem_ff[{addr_ff[6:3], i[2:0]}] & buf_ff[i];
      end
    end
  end

  // ==========================================================
  // bytes offered to the output buffer
  always @*
  begin
    push_vld  = 1'b0;
    push_data = 8'h00;
    case (state_ff)
      S_CACRC, S_RCRC, S_WCRC:
      begin
        push_vld  = 1'b1;
        push_data = crc_ff;
      end
      S_RDATA:
      begin
        push_vld  = 1'b1;
        push_data = is_stat ? stat_byte(addr_ff[2:0]) : mem_ff[addr_ff[6:0]];
      end
      S_WVER:
      begin
        push_vld  = 1'b1;
        push_data = mem_ff[{addr_ff[6:3], idx_ff}];
      end
      default:
      begin
        push_vld  = 1'b0;
        push_data = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // command sequencer
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:
        if (rx_done)
          nxt_state = (rx_byte == `CMD_SKIP_ROM) ? S_FUNC : S_ONES;
      S_FUNC:
        if (rx_done)
        begin
          if ((rx_byte == `CMD_RD_PAGE) || (rx_byte == `CMD_RD_FIELD) ||
              (rx_byte == `CMD_WR_MEM) || (rx_byte == `CMD_RD_STAT))
            nxt_state = S_ADRL;
          else
            nxt_state = S_ONES;
        end
      S_ADRL:
        if (rx_done)
          nxt_state = S_ADRH;
      S_ADRH:
        if (rx_done)
          nxt_state = S_CACRC;
      S_CACRC:
        if (accepted)
          nxt_state = is_write ? S_WDATA : (at_end ? S_ONES : S_RDATA);
      S_RDATA:
        if (accepted)
        begin
          if ((is_stat && addr_ff[2:0] == `STAT_LAST) ||
              (!is_stat && addr_ff[6:0] == `MEM_LAST) ||
              (is_page && addr_ff[4:0] == `PAGE_LAST))
            nxt_state = S_RCRC;
        end
      S_RCRC:
        if (accepted)
          nxt_state = at_end ? S_ONES : S_RDATA;
      S_WDATA:
        if (rx_done && idx_ff == `SEG_LAST)
          nxt_state = S_WCRC;
      S_WCRC:
        if (accepted)
          nxt_state = S_WPROG;
      S_WPROG:
        if (rx_done)
          nxt_state = (rx_byte == `CMD_PROGRAM) ? S_WPULS : S_ONES;
      S_WPULS:
        if (commit)
          nxt_state = S_WVER;
      S_WVER:
        if (accepted && idx_ff == `SEG_LAST)
          nxt_state = S_ONES;
      S_ONES:
        nxt_state = S_ONES;
      default:
        nxt_state = S_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff     <= S_IDLE;
      cmd_ff       <= 8'h00;
      addr_ff      <= 16'h0000;
      crc_ff       <= `CRC_INIT;
      rx_sh_ff     <= 8'h00;
      rx_cnt_ff    <= 3'h0;
      idx_ff       <= 3'h0;
      presence_ff  <= 1'b0;
      prog_done_ff <= 1'b0;
    end
    else if (rst_ok)
    begin
      state_ff     <= S_IDLE;
      cmd_ff       <= 8'h00;
      addr_ff      <= 16'h0000;
      crc_ff       <= `CRC_INIT;
      rx_sh_ff     <= 8'h00;
      rx_cnt_ff    <= 3'h0;
      idx_ff       <= 3'h0;
      presence_ff  <= 1'b1;
      prog_done_ff <= 1'b0;
    end
    else
    begin
      state_ff     <= nxt_state;
      presence_ff  <= 1'b0;
      prog_done_ff <= commit;
      if (wr_bit_valid)
      begin
        rx_sh_ff  <= rx_byte;
        rx_cnt_ff <= rx_cnt_ff + 1'b1;
      end
      if (rx_done)
      begin
        case (state_ff)
          S_FUNC:
          begin
            cmd_ff <= rx_byte;
            crc_ff <= crc_byte(`CRC_INIT, rx_byte);
          end
          S_ADRL:
          begin
            addr_ff[7:0] <= rx_byte;
            crc_ff       <= crc_byte(crc_ff, rx_byte);
          end
          S_ADRH:
          begin
            addr_ff[15:8] <= rx_byte;
            crc_ff        <= crc_byte(crc_ff, rx_byte);
          end
          S_WDATA:
          begin
            idx_ff <= idx_ff + 1'b1;
            crc_ff <= crc_byte(crc_ff, rx_byte);
          end
          default:
            crc_ff <= crc_ff;
        endcase
      end
      if (accepted)
      begin
        case (state_ff)
          S_CACRC, S_RCRC, S_WCRC:
            crc_ff <= `CRC_INIT;
          S_RDATA:
          begin
            crc_ff  <= crc_byte(crc_ff, push_data);
            addr_ff <= addr_ff + 1'b1;
          end
          S_WVER:
            idx_ff <= idx_ff + 1'b1;
          default:
            crc_ff <= crc_ff;
        endcase
      end
      if (commit)
        idx_ff <= 3'h0;
    end
  end

  // ==========================================================
  // output buffer and read-slot serializer
  otp_obuf_fifo
  #(
    .WIDTH (`OBUF_WIDTH),
    .DEPTH (`OBUF_DEPTH),
    .AW    (`OBUF_AW)
  )
  u_obuf
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .clr       (rst_ok),
    .in_valid  (push_vld),
    .in_ready  (push_rdy),
    .in_data   (push_data),
    .out_valid (pop_vld),
    .out_ready (pop_rdy),
    .out_data  (pop_data)
  );

  assign pop_rdy = rd_slot && (tx_left_ff == 3'h0) && !rst_ok;

  // slots outrun by an empty buffer answer one; bytes take one clock, slots many
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_bit_ff     <= `ONES_BIT;
      rd_bit_vld_ff <= 1'b0;
      tx_sh_ff      <= 8'h00;
      tx_left_ff    <= 3'h0;
    end
    else if (rst_ok)
    begin
      rd_bit_ff     <= `ONES_BIT;
      rd_bit_vld_ff <= 1'b0;
      tx_sh_ff      <= 8'h00;
      tx_left_ff    <= 3'h0;
    end
    else
    begin
      rd_bit_vld_ff <= rd_slot;
      if (rd_slot)
      begin
        if (tx_left_ff != 3'h0)
        begin
          rd_bit_ff  <= tx_sh_ff[0];
          tx_sh_ff   <= {1'b1, tx_sh_ff[7:1]};
          tx_left_ff <= tx_left_ff - 1'b1;
        end
        else if (pop_vld)
        begin
          rd_bit_ff  <= pop_data[0];
          tx_sh_ff   <= {1'b1, pop_data[7:1]};
          tx_left_ff <= 3'h7;
        end
        else
          rd_bit_ff <= `ONES_BIT;
      end
    end
  end

endmodule

`default_nettype wire

//--- otp_seq_regs.vh
// constants of the otp memory command sequencer
`ifndef OTP_SEQ_REGS_VH
`define OTP_SEQ_REGS_VH

// command codes
`define CMD_SKIP_ROM   8'hcc
`define CMD_RD_PAGE    8'hc3
`define CMD_RD_FIELD   8'hf0
`define CMD_WR_MEM     8'h0f
`define CMD_RD_STAT    8'haa
`define CMD_PROGRAM    8'h5a

// crc x^8+x^5+x^4+1, lsb-first (reflected) form
`define CRC_POLY_REFL  8'h8c
`define CRC_INIT       8'h00

// memory layout
`define MEM_BYTES      128
`define MEM_LAST       7'h7f
`define PAGE_LAST      5'h1f
`define STAT_LAST      3'h7
`define SEG_LAST       3'h7
`define DATA_ERASED    8'hff
`define STAT_ERASED    8'hff
`define STAT_FACTORY   8'h00
`define ONES_BIT       1'b1

// timing
`define CLK_MHZ        10
`define PROG_US        2500
`define RST_US         480

// output buffer
`define OBUF_WIDTH     8
`define OBUF_DEPTH     16
`define OBUF_AW        4

`endif

//--- otp_obuf_fifo.v
// byte fifo between the sequencer and the read-slot serializer
`timescale 1ns/100ps
`default_nettype none

module otp_obuf_fifo
#(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
)
(
  input  wire             clk_sys,
  input  wire             rst_b,
  input  wire             clr,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  // ==========================================================
  // storage and pointers
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;

  wire do_wr;
  wire do_rd;

  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rd_ptr_ff];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always @(posedge clk_sys)
  begin
    if (do_wr)
    begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // clear drops whatever a reset pulse left unread
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end
    else if (clr)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count_ff <= count_ff + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- otp_seq_props.sv
// assertions on the port timing of the otp memory sequencer
`timescale 1ns/100ps
`default_nettype none
module otp_seq_props
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic rst_pulse,
  input wire logic wr_bit_valid,
  input wire logic wr_bit,
  input wire logic rd_slot,
  input wire logic prog_pin,
  input wire logic rd_bit_ff,
  input wire logic rd_bit_vld_ff,
  input wire logic presence_ff,
  input wire logic prog_done_ff
);
  // ======
  // helpers
  logic [2:0] hist_ff;
  logic [2:0] low_cnt_ff;
  logic       calm;
  // pin low long enough that the synchroniser shows it low
  assign calm = !prog_pin && (hist_ff == 3'h0);
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      hist_ff    <= 3'h0;
      low_cnt_ff <= 3'h7;
    end
    else
    begin
      hist_ff    <= {hist_ff[1:0], prog_pin};
      low_cnt_ff <= prog_pin ? 3'h0 : (low_cnt_ff == 3'h7) ? 3'h7 : low_cnt_ff + 3'h1;
    end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ======
  // assertions
  chk_slot_answer: assert property (rd_slot |=> rd_bit_vld_ff)
    else $error("read slot not answered next cycle");
  chk_slot_quiet: assert property (!rd_slot |=> !rd_bit_vld_ff)
    else $error("read answer without a slot");
  chk_pres_answer: assert property (rst_pulse && calm |=> presence_ff)
    else $error("no presence after reset pulse");
  chk_pres_cause: assert property (presence_ff |-> $past(rst_pulse))
    else $error("presence without reset pulse");
  chk_idle_ones: assert property (rst_pulse && calm ##2 rd_slot |=> rd_bit_ff)
    else $error("stale data after reset pulse");
  chk_done_pulse: assert property (prog_done_ff |=> !prog_done_ff)
    else $error("program done longer than a cycle");
  chk_done_fall: assert property (prog_done_ff |-> low_cnt_ff inside {[3'h1:3'h6]})
    else $error("program done not tied to pulse end");
  chk_bit_hold: assert property (!rd_bit_vld_ff && !$past(rst_pulse) |-> $stable(rd_bit_ff))
    else $error("read bit moved between slots");
  cover property (prog_done_ff);
  cover property (presence_ff);
  cover property (rd_slot ##1 !rd_bit_ff);
endmodule
bind otp_mem_seq otp_seq_props u_props
(
  .clk_sys(clk_sys),
  .rst_b(rst_b),
  .rst_pulse(rst_pulse),
  .wr_bit_valid(wr_bit_valid),
  .wr_bit(wr_bit),
  .rd_slot(rd_slot),
  .prog_pin(prog_pin),
  .rd_bit_ff(rd_bit_ff),
  .rd_bit_vld_ff(rd_bit_vld_ff),
  .presence_ff(presence_ff),
  .prog_done_ff(prog_done_ff)
);
`default_nettype wire

//--- otp_host_model.sv
// bus host model driving the bit-slot strobes of the sequencer
`timescale 1ns/100ps
`default_nettype none
module otp_host_model
(
  input  wire logic clk_sys,
  input  wire logic rd_bit_ff,
  input  wire logic rd_bit_vld_ff,
  input  wire logic presence_ff,
  output var  logic rst_pulse,
  output var  logic wr_bit_valid,
  output var  logic wr_bit,
  output var  logic rd_slot,
  output var  logic prog_pin
);
  // ======
  // line idle
  initial
  begin
    rst_pulse    = 1'b0;
    wr_bit_valid = 1'b0;
    wr_bit       = 1'b0;
    rd_slot      = 1'b0;
    prog_pin     = 1'b0;
  end
  // ======
  // slot tasks
  task automatic bus_reset(output logic pres);
    @(posedge clk_sys) rst_pulse <= 1'b1;
    @(posedge clk_sys) rst_pulse <= 1'b0;
    @(negedge clk_sys) pres = presence_ff;
  endtask
  task automatic send_byte(input logic [7:0] b, input int gap);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      wr_bit_valid <= 1'b1;
      wr_bit       <= b[i];
      @(posedge clk_sys);
      wr_bit_valid <= 1'b0;
      wr_bit       <= ~b[i]; // complement of the bit, no stale level
      repeat (gap) @(posedge clk_sys);
    end
  endtask
  task automatic read_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      rd_slot <= 1'b1;
      @(posedge clk_sys);
      rd_slot <= 1'b0;
      @(negedge clk_sys);
      b[i] = rd_bit_vld_ff ? rd_bit_ff : 1'bx;
    end
  endtask
  // poke breaks the host side on purpose: reset inside the pulse
  task automatic prog_pulse(input int len, input logic poke);
    @(posedge clk_sys);
    prog_pin <= 1'b1;
    repeat (len / 2) @(posedge clk_sys);
    rst_pulse <= poke;
    @(posedge clk_sys);
    rst_pulse <= 1'b0;
    repeat (len / 2) @(posedge clk_sys);
    prog_pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb_otp_eprom_memory_commands.sv
// self-checking bench of the otp memory command sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_otp_eprom_memory_commands;
  localparam int PROG = 20;
  logic       clk_sys;
  logic       rst_b;
  logic       rst_pulse, wr_bit_valid, wr_bit, rd_slot, prog_pin;
  logic       rd_bit_ff, rd_bit_vld_ff, presence_ff, prog_done_ff;
  int         n_fail, n_compared, cyc;
  logic [7:0] mem [128];
  logic [7:0] exp_q [$];
  logic [7:0] got, seg, crc;
  logic       pres;
  otp_mem_seq #(.PROG_CYC(PROG)) u_dut
  (
    .clk_sys(clk_sys), .rst_b(rst_b), .rst_pulse(rst_pulse),
    .wr_bit_valid(wr_bit_valid), .wr_bit(wr_bit), .rd_slot(rd_slot),
    .prog_pin(prog_pin), .rd_bit_ff(rd_bit_ff), .rd_bit_vld_ff(rd_bit_vld_ff),
    .presence_ff(presence_ff), .prog_done_ff(prog_done_ff)
  );
  otp_host_model u_host
  (
    .clk_sys(clk_sys), .rd_bit_ff(rd_bit_ff), .rd_bit_vld_ff(rd_bit_vld_ff),
    .presence_ff(presence_ff), .rst_pulse(rst_pulse), .wr_bit_valid(wr_bit_valid),
    .wr_bit(wr_bit), .rd_slot(rd_slot), .prog_pin(prog_pin)
  );
  // ======
  // model and checks
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8c) : (c >> 1);
    return c;
  endfunction
  task automatic cmp(input logic [7:0] got_v, input logic [7:0] exp_v);
    n_compared++;
    if (got_v !== exp_v)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic drain();
    while (exp_q.size() > 0)
    begin
      u_host.read_byte(got);
      cmp(got, exp_q.pop_front());
    end
  endtask
  task automatic start(input logic [7:0] cmd, input logic [7:0] lo);
    u_host.bus_reset(pres);
    cmp({7'h0, pres}, 8'h01);
    u_host.send_byte(8'hcc, 0);
    u_host.send_byte(cmd, $urandom_range(2));
    u_host.send_byte(lo, 0);
    u_host.send_byte(8'h00, 1);
    repeat (25) @(posedge clk_sys);
    exp_q = {crc8(crc8(crc8(8'h00, cmd), lo), 8'h00)};
  endtask
  // kind 0 page crc, 1 field crc, 2 status
  task automatic build(input int kind, input int a);
    int last;
    last = (kind == 2) ? 7 : 127;
    crc = 8'h00;
    for (int i = a; i <= last; i++)
    begin
      seg = (kind == 2) ? ((i == 7) ? 8'h00 : 8'hff) : mem[i];
      exp_q.push_back(seg);
      crc = crc8(crc, seg);
      if (i == last || (kind == 0 && i % 32 == 31))
      begin
        exp_q.push_back(crc);
        crc = 8'h00;
      end
    end
    exp_q.push_back(8'hff);
  endtask
  task automatic write_seg(input logic [6:0] a, input logic poke);
    logic [7:0] dat [8];
    start(8'h0f, {1'b0, a});
    drain();
    crc = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      dat[i] = $urandom;
      crc = crc8(crc, dat[i]);
      u_host.send_byte(dat[i], $urandom_range(3));
    end
    repeat (25) @(posedge clk_sys);
    exp_q = {crc};
    drain();
    u_host.send_byte(8'h5a, 0);
    u_host.prog_pulse(PROG + 4, poke);
    for (int k = 0; k < 10; k++)
    begin
      @(negedge clk_sys);
      if (prog_done_ff === 1'b1)
        break;
    end
    cmp({7'h0, prog_done_ff}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      mem[a + i] = mem[a + i] & dat[i];
      exp_q.push_back(mem[a + i]);
    end
    exp_q.push_back(8'hff);
    repeat (25) @(posedge clk_sys);
    drain();
  endtask
  // ======
  // clock, timeout, sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  initial
  begin
    rst_b = 1'b0;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    for (int i = 0; i < 128; i++)
      mem[i] = 8'hff;
    void'($urandom(32'hf92a));
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    seg = {1'b0, 4'($urandom_range(15)), 3'h0};
    start(8'hc3, 8'h1e);
    build(0, 30);
    drain();
    write_seg(seg[6:0], 1'b0);
    write_seg(seg[6:0], 1'b1);
    got = seg;
    start(8'hf0, got);
    build(1, int'(got));
    drain();
    start(8'hf0, 8'h80);
    exp_q.push_back(8'hff);
    drain();
    start(8'hf0, 8'h10);
    build(1, 16);
    for (int i = 0; i < 4; i++)
    begin
      u_host.read_byte(got);
      cmp(got, exp_q.pop_front());
    end
    u_host.bus_reset(pres);
    u_host.read_byte(got);
    cmp(got, 8'hff);
    start(8'haa, 8'h05);
    build(2, 5);
    drain();
    u_host.bus_reset(pres);
    u_host.send_byte(8'hc3, 0);
    u_host.send_byte(8'h00, 0);
    u_host.send_byte(8'h00, 0);
    repeat (25) @(posedge clk_sys);
    u_host.read_byte(got);
    cmp(got, 8'hff);
    start(8'h3c, 8'h00);
    exp_q = {8'hff};
    drain();
    wrap_up();
  end
endmodule
`default_nettype wire
